// *** rtl/logical_device_config_regs.sv ***
// Purpose: Vendor configuration registers of several logical devices
// Assumes: Classic Wishbone slave, one wait state, hard reset on srst_in
// Notes:   Word 0x07 selects logical device, index = adr[9:2]
//
// Local design decision: the Wishbone slave port.
`timescale 1ns/1ps
// Overview of operation
// - Only hard reset restores defaults
// - Floppy mode at F0, resets 0E
// - Density field forces output one or zero
// - Floppy option at F1, resets zero
// - Boot drive field selects drive
// - Drive type register F2 resets FF
// - Index F3 reads zero always
// - Drive0 settings F4, holes read zero
// - Drive1 settings mirror drive0 layout
// - First channel uses first buffer enable
// - Second channel buffer enable steering bit
// - Active channel pins outputs, else float
// - Wide addressing turns inactive channel pins into SA13-15
// - Parallel port mode field codes
// - FIFO threshold default, register 3C
// - Pulsed low interrupt then float
// - Interrupt follows ack or level
// - Type bit ignored in plain modes
// - Serial MIDI enable bit zero
// - Serial high speed bit one
module logical_device_config_regs (
	// Clock and hard reset
	input  wire logic        clock_in,
	input  wire logic        srst_in,
	// Wishbone slave
	input  wire logic        wb_cyc_in,
	input  wire logic        wb_stb_in,
	input  wire logic        wb_we_in,
	input  wire logic [31:0] wb_adr_in,
	input  wire logic [3:0]  wb_sel_in,
	input  wire logic [31:0] wb_dat_in,
	output logic [31:0]      wb_dat_out,
	output logic             wb_ack_out,
	// Floppy controls
	input  wire logic        density_in,
	output logic             density_out,
	output logic [1:0]       boot_drive_out,
	output logic             boot_valid_out,
	output logic [1:0]       drive_a_type_out,
	output logic [1:0]       drive_b_type_out,
	output logic [7:0]       drive0_settings_out,
	output logic [7:0]       drive1_settings_out,
	// Disk buffer enables
	input  wire logic        disk1_access_in,
	input  wire logic        disk2_access_in,
	output logic             disk_primary_buffer_enable_out,
	output logic             disk_secondary_buffer_enable_out,
	// Second channel pins
	input  wire logic [1:0]  disk2_cs_req_in,
	input  wire logic        disk2_chip_select_a_in,
	input  wire logic        disk2_chip_select_b_in,
	input  wire logic        disk2_interrupt_pin_in,
	input  wire logic        chip_select_input_in,
	output logic             disk2_chip_select_a_out,
	output logic             disk2_chip_select_a_oe_out,
	output logic             disk2_chip_select_b_out,
	output logic             disk2_chip_select_b_oe_out,
	output logic             disk2_irq_out,
	output logic [3:0]       high_addr_out,
	output logic             high_addr_valid_out,
	// Parallel port
	input  wire logic        pp_ack_in,
	input  wire logic        pp_level_req_in,
	output logic [2:0]       pp_mode_out,
	output logic [3:0]       pp_fifo_threshold_out,
	output logic             pp_irq_out,
	output logic             pp_irq_oe_out,
	// Serial port 1
	output logic             serial1_midi_out,
	output logic             serial1_high_speed_out
);
	typedef struct packed {
		logic [7:0] ldn;
		logic [7:0] ctrl;
		logic [7:0] fmode;
		logic [7:0] fopt;
		logic [7:0] ftype;
		logic [7:0] drv0;
		logic [7:0] drv1;
		logic [7:0] d1mode;
		logic [7:0] d2mode;
		logic [7:0] ppmode;
		logic [7:0] s1mode;
		logic       ack;
		logic [31:0] rdata;
		logic       dens;
		logic       pbuf;
		logic       sbuf;
	} regs_t;
	regs_t r;
	regs_t next_r;
	logic [7:0] idx;
	logic [7:0] wv;
	logic       req;
	logic       wr;
	logic [7:0] rd;
	logic       d2_active;
	logic       wide;
	logic [1:0] dsel;

	assign idx       = wb_adr_in[9:2];
	assign wv        = wb_dat_in[7:0];
	assign req       = wb_cyc_in & wb_stb_in & ~r.ack;
	assign wr        = req & wb_we_in & wb_sel_in[0];
	assign d2_active = r.ctrl[ldcfg_pkg::CTRL_DISK2_ACTIVE];
	assign wide      = r.ctrl[ldcfg_pkg::CTRL_WIDE_ADDR];
	assign dsel      = r.fopt[ldcfg_pkg::DENS_LO +: 2];

	// Read mux; unmapped indices and holes return zero
	always_comb begin
		rd = 8'h00;
		if (idx == ldcfg_pkg::IDX_LDN_SEL) begin
			rd = r.ldn;
		end else if (idx == ldcfg_pkg::IDX_CTRL) begin
			rd = r.ctrl;
		end else begin
			case (r.ldn)
				ldcfg_pkg::LDN_FLOPPY: begin
					case (idx)
						ldcfg_pkg::IDX_MODE:   rd = r.fmode;
						ldcfg_pkg::IDX_OPTION: rd = r.fopt;
						ldcfg_pkg::IDX_TYPE:   rd = r.ftype;
						ldcfg_pkg::IDX_RSVD:   rd = 8'h00;
						ldcfg_pkg::IDX_DRIVE0: rd = r.drv0;
						ldcfg_pkg::IDX_DRIVE1: rd = r.drv1;
						default:               rd = 8'h00;
					endcase
				end
				ldcfg_pkg::LDN_DISK1: begin
					if (idx == ldcfg_pkg::IDX_MODE) begin
						rd = r.d1mode;
					end
				end
				ldcfg_pkg::LDN_DISK2: begin
					if (idx == ldcfg_pkg::IDX_MODE) begin
						rd = r.d2mode;
					end
				end
				ldcfg_pkg::LDN_PARALLEL: begin
					if (idx == ldcfg_pkg::IDX_MODE) begin
						rd = r.ppmode;
					end
				end
				ldcfg_pkg::LDN_SERIAL1: begin
					if (idx == ldcfg_pkg::IDX_MODE) begin
						rd = r.s1mode;
					end
				end
				default: rd = 8'h00;
			endcase
		end
	end

	// Writes are masked so reserved holes can never be set
	always_comb begin
		next_r = r;
		next_r.ack = req;
		next_r.rdata = {24'h000000, rd};
		if (wr) begin
			if (idx == ldcfg_pkg::IDX_LDN_SEL) begin
				next_r.ldn = wv;
			end else if (idx == ldcfg_pkg::IDX_CTRL) begin
				next_r.ctrl = wv & ldcfg_pkg::MASK_CTRL;
			end else begin
				case (r.ldn)
					ldcfg_pkg::LDN_FLOPPY: begin
						case (idx)
							ldcfg_pkg::IDX_MODE:   next_r.fmode = wv;
							ldcfg_pkg::IDX_OPTION: begin
								next_r.fopt = wv & ldcfg_pkg::MASK_OPTION;
							end
							ldcfg_pkg::IDX_TYPE:   next_r.ftype = wv;
							ldcfg_pkg::IDX_DRIVE0: begin
								next_r.drv0 = wv & ldcfg_pkg::MASK_DRIVE;
							end
							ldcfg_pkg::IDX_DRIVE1: begin
								next_r.drv1 = wv & ldcfg_pkg::MASK_DRIVE;
							end
							default: next_r.fmode = r.fmode;
						endcase
					end
					ldcfg_pkg::LDN_DISK1: begin
						if (idx == ldcfg_pkg::IDX_MODE) begin
							next_r.d1mode = wv;
						end
					end
					ldcfg_pkg::LDN_DISK2: begin
						if (idx == ldcfg_pkg::IDX_MODE) begin
							next_r.d2mode = wv & ldcfg_pkg::MASK_DISK2;
						end
					end
					ldcfg_pkg::LDN_PARALLEL: begin
						if (idx == ldcfg_pkg::IDX_MODE) begin
							next_r.ppmode = wv;
						end
					end
					ldcfg_pkg::LDN_SERIAL1: begin
						if (idx == ldcfg_pkg::IDX_MODE) begin
							next_r.s1mode = wv & ldcfg_pkg::MASK_SERIAL1;
						end
					end
					default: next_r.ldn = r.ldn;
				endcase
			end
		end
		// Density override: 10 forces one, 11 forces zero
		next_r.dens = dsel[1] ? ~dsel[0] : density_in;
		// Buffer steering; channel one always drives the primary enable
		next_r.pbuf = disk1_access_in | (r.d2mode[0] & disk2_access_in);
		next_r.sbuf = ~r.d2mode[0] & disk2_access_in;
	end

	// Only the hard reset reaches this bank; soft reset is not an input
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			r        <= '0;
			r.fmode  <= ldcfg_pkg::RST_FLOPPY_MODE;
			r.fopt   <= ldcfg_pkg::RST_FLOPPY_OPTION;
			r.ftype  <= ldcfg_pkg::RST_FLOPPY_TYPE;
			r.drv0   <= ldcfg_pkg::RST_DRIVE;
			r.drv1   <= ldcfg_pkg::RST_DRIVE;
			r.d1mode <= ldcfg_pkg::RST_DISK1_MODE;
			r.d2mode <= ldcfg_pkg::RST_DISK2_MODE;
			r.ppmode <= ldcfg_pkg::RST_PP_MODE;
			r.s1mode <= ldcfg_pkg::RST_SERIAL1_MODE;
			r.ctrl   <= ldcfg_pkg::RST_CTRL;
		end else begin
			r <= next_r;
		end
	end

	// Bus answers
	assign wb_ack_out = r.ack;
	assign wb_dat_out = r.rdata;

	// Floppy outputs
	assign density_out         = r.dens;
	assign boot_drive_out      = r.fopt[ldcfg_pkg::BOOT_LO +: 2];
	assign boot_valid_out      = ~r.fopt[7];
	assign drive_a_type_out    = r.ftype[1:0];
	assign drive_b_type_out    = r.ftype[3:2];
	assign drive0_settings_out = r.drv0;
	assign drive1_settings_out = r.drv1;

	// Disk buffer enables
	assign disk_primary_buffer_enable_out   = r.pbuf;
	assign disk_secondary_buffer_enable_out = r.sbuf;

	// Second channel pin roles follow active and wide addressing bits
	assign disk2_chip_select_a_out    = ~disk2_cs_req_in[0];
	assign disk2_chip_select_b_out    = ~disk2_cs_req_in[1];
	assign disk2_chip_select_a_oe_out = d2_active;
	assign disk2_chip_select_b_oe_out = d2_active;
	assign disk2_irq_out = d2_active & disk2_interrupt_pin_in;
	// SA12 always comes from the chip select pin
	assign high_addr_out = {disk2_interrupt_pin_in, disk2_chip_select_b_in,
		disk2_chip_select_a_in, chip_select_input_in};
	assign high_addr_valid_out = ~d2_active & wide;

	// Parallel and serial fields
	assign pp_mode_out            = r.ppmode[2:0];
	assign pp_fifo_threshold_out  = r.ppmode[ldcfg_pkg::PP_THR_LO +: 4];
	assign serial1_midi_out       = r.s1mode[0];
	assign serial1_high_speed_out = r.s1mode[1];

	// Parallel port interrupt shaping
	pp_irq_shaper u_pp_irq (
		.clock_in     (clock_in),
		.srst_in      (srst_in),
		.pp_mode_in   (r.ppmode),
		.ack_in       (pp_ack_in),
		.level_req_in (pp_level_req_in),
		.irq_out      (pp_irq_out),
		.irq_oe_out   (pp_irq_oe_out)
	);

	property p_holes;
		@(posedge clock_in) disable iff (srst_in)
		r.drv0[2] == 1'b0 && r.drv0[5] == 1'b0 && r.drv0[7] == 1'b0
		&& r.drv1[7] == 1'b0 && r.fopt[1:0] == 2'h0;
	endproperty
	a_holes: assert property (p_holes)
		else $error("reserved bit set");
	property p_rsvd_read;
		@(posedge clock_in) disable iff (srst_in)
		req && r.ldn == 8'h00 && idx == 8'hF3 |=> wb_ack_out && wb_dat_out == 0;
	endproperty
	a_rsvd_read: assert property (p_rsvd_read)
		else $error("reserved index read nonzero");
	property p_reset_vals;
		@(posedge clock_in) srst_in |=> r.fmode == 8'h0E && r.ftype == 8'hFF
		&& r.ppmode == 8'h3C && r.fopt == 8'h00;
	endproperty
	a_reset_vals: assert property (p_reset_vals)
		else $error("reset value wrong");
	property p_dens;
		@(posedge clock_in) disable iff (srst_in)
		dsel == 2'h3 |=> !density_out;
	endproperty
	a_dens: assert property (p_dens)
		else $error("density not forced low");
	property p_float;
		@(posedge clock_in) disable iff (srst_in)
		!d2_active |-> !disk2_chip_select_a_oe_out && !disk2_irq_out;
	endproperty
	a_float: assert property (p_float)
		else $error("inactive channel driving");
	property p_steer;
		@(posedge clock_in) disable iff (srst_in)
		r.d2mode[0] |=> !disk_secondary_buffer_enable_out;
	endproperty
	a_steer: assert property (p_steer)
		else $error("secondary enable used while steered");
	property p_ack_once;
		@(posedge clock_in) disable iff (srst_in)
		wb_ack_out |=> !wb_ack_out;
	endproperty
	a_ack_once: assert property (p_ack_once)
		else $error("ack held two cycles");
	property p_s1;
		@(posedge clock_in) disable iff (srst_in)
		wr && r.ldn == 8'h04 && idx == 8'hF0
		|=> r.s1mode == {6'h00, $past(wv[1:0])};
	endproperty
	a_s1: assert property (p_s1)
		else $error("serial mode write wrong");
	property p_primary;
		@(posedge clock_in) disable iff (srst_in)
		disk1_access_in |=> disk_primary_buffer_enable_out;
	endproperty
	a_primary: assert property (p_primary)
		else $error("first channel buffer not enabled");
	property p_type_write;
		@(posedge clock_in) disable iff (srst_in)
		wr && r.ldn == 8'h00 && idx == 8'hF2 |=> r.ftype == $past(wv);
	endproperty
	a_type_write: assert property (p_type_write)
		else $error("drive type write lost");
endmodule : logical_device_config_regs

// *** rtl/ldcfg_pkg.sv ***
// Purpose: Shared constants for the logical device configuration bank
// Assumes: Wishbone byte addresses, one 32-bit word per register
// Notes:   Logical device number selects the bank, index selects register
package ldcfg_pkg;
	// Logical device numbers
	localparam logic [7:0] LDN_FLOPPY   = 8'h00;
	localparam logic [7:0] LDN_DISK1    = 8'h01;
	localparam logic [7:0] LDN_DISK2    = 8'h02;
	localparam logic [7:0] LDN_PARALLEL = 8'h03;
	localparam logic [7:0] LDN_SERIAL1  = 8'h04;
	// Register indices
	localparam logic [7:0] IDX_MODE     = 8'hF0;
	localparam logic [7:0] IDX_OPTION   = 8'hF1;
	localparam logic [7:0] IDX_TYPE     = 8'hF2;
	localparam logic [7:0] IDX_RSVD     = 8'hF3;
	localparam logic [7:0] IDX_DRIVE0   = 8'hF4;
	localparam logic [7:0] IDX_DRIVE1   = 8'hF5;
	// Bus words: logical device select and wide addressing control
	localparam logic [7:0] IDX_LDN_SEL  = 8'h07;
	localparam logic [7:0] IDX_CTRL     = 8'h08;
	// Reset values
	localparam logic [7:0] RST_FLOPPY_MODE   = 8'h0E;
	localparam logic [7:0] RST_FLOPPY_OPTION = 8'h00;
	localparam logic [7:0] RST_FLOPPY_TYPE   = 8'hFF;
	localparam logic [7:0] RST_DRIVE         = 8'h00;
	localparam logic [7:0] RST_DISK2_MODE    = 8'h00;
	localparam logic [7:0] RST_DISK1_MODE    = 8'h00;
	localparam logic [7:0] RST_PP_MODE       = 8'h3C;
	localparam logic [7:0] RST_SERIAL1_MODE  = 8'h00;
	localparam logic [7:0] RST_CTRL          = 8'h00;
	// Writable masks
	localparam logic [7:0] MASK_OPTION  = 8'hFC;
	localparam logic [7:0] MASK_DRIVE   = 8'h5B;
	localparam logic [7:0] MASK_DISK2   = 8'h01;
	localparam logic [7:0] MASK_SERIAL1 = 8'h03;
	localparam logic [7:0] MASK_CTRL    = 8'h03;
	// Control word fields
	localparam int CTRL_DISK2_ACTIVE = 0;
	localparam int CTRL_WIDE_ADDR    = 1;
	// Parallel port modes
	localparam logic [2:0] PP_PRINTER = 3'h4;
	localparam logic [2:0] PP_SPP     = 3'h0;
	localparam logic [2:0] PP_EPP19   = 3'h1;
	localparam logic [2:0] PP_EPP17   = 3'h5;
	localparam logic [2:0] PP_ECP     = 3'h2;
	localparam logic [2:0] PP_ECP19   = 3'h3;
	localparam logic [2:0] PP_ECP17   = 3'h7;
	// Field positions
	localparam int PP_INT_TYPE = 7;
	localparam int DENS_LO     = 2;
	localparam int BOOT_LO     = 6;
	localparam int PP_THR_LO   = 3;
	// Length of pulsed parallel port interrupt, cycles
	localparam int PP_PULSE_CYCLES = 2;
endpackage : ldcfg_pkg

// *** rtl/pp_irq_shaper.sv ***
// Purpose: Shapes the parallel port interrupt from the mode register
// Assumes: Acknowledge and level request inputs synchronous to clock_in
// Notes:   Pulsed style drives low briefly then floats the pin
`timescale 1ns/1ps
module pp_irq_shaper (
	// Clock and reset
	input  wire logic       clock_in,
	input  wire logic       srst_in,
	// Configuration
	input  wire logic [7:0] pp_mode_in,
	// Sources
	input  wire logic       ack_in,
	input  wire logic       level_req_in,
	// Pin
	output logic            irq_out,
	output logic            irq_oe_out
);
	typedef struct packed {
		logic       ack_d;
		logic [1:0] cnt;
		logic       irq;
		logic       oe;
	} shp_t;
	shp_t st;
	shp_t next_st;
	logic [2:0] md;
	logic       ecp_sub;
	logic       edge_ack;

	assign md       = pp_mode_in[2:0];
	assign ecp_sub  = md[1];
	assign edge_ack = ack_in & ~st.ack_d;

	// Style follows interrupt-type bit except in the two plain modes
	always_comb begin
		next_st = st;
		next_st.ack_d = ack_in;
		if (md == ldcfg_pkg::PP_PRINTER || md == ldcfg_pkg::PP_SPP) begin
			next_st.irq = ack_in;
			next_st.oe  = 1'b1;
			next_st.cnt = 2'h0;
		end else if (pp_mode_in[ldcfg_pkg::PP_INT_TYPE]) begin
			if (edge_ack) begin
				next_st.cnt = 2'(ldcfg_pkg::PP_PULSE_CYCLES);
			end else if (st.cnt != 2'h0) begin
				next_st.cnt = st.cnt - 2'h1;
			end
			next_st.irq = 1'b0;
			next_st.oe  = edge_ack | (st.cnt > 2'h1);
		end else begin
			next_st.irq = ecp_sub ? level_req_in : ack_in;
			next_st.oe  = 1'b1;
			next_st.cnt = 2'h0;
		end
	end

	// Outputs come straight from the flops
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	assign irq_out    = st.irq;
	assign irq_oe_out = st.oe;

	// Checked one cycle on, so a mode change never trips it
	property p_pulse_low;
		@(posedge clock_in) disable iff (srst_in)
		pp_mode_in[7] && md != 3'h4 && md != 3'h0 |=> !irq_out;
	endproperty
	a_pulse_low: assert property (p_pulse_low)
		else $error("pulsed interrupt not low");
	property p_plain;
		@(posedge clock_in) disable iff (srst_in)
		!srst_in && (md == 3'h4 || md == 3'h0)
		##1 (md == 3'h4 || md == 3'h0)
		|-> irq_oe_out && irq_out == $past(ack_in);
	endproperty
	a_plain: assert property (p_plain)
		else $error("plain mode interrupt wrong");
endmodule : pp_irq_shaper

// *** verif/wb_host_model.sv ***
// Purpose: Classic Wishbone master standing in for the host processor
// Assumes: Slave answers each request with a one-cycle ack
// Notes:   Released address and data are inverted so a stale value never helps
`timescale 1ns/1ps
module wb_host_model (
	// Clock
	input  wire logic        clock_in,
	// Answer from slave
	input  wire logic        wb_ack_in,
	input  wire logic [31:0] wb_dat_in,
	// Request to slave
	output logic             wb_cyc_out,
	output logic             wb_stb_out,
	output logic             wb_we_out,
	output logic [31:0]      wb_adr_out,
	output logic [3:0]       wb_sel_out,
	output logic [31:0]      wb_dat_out
);
	// Idle bus from time zero
	initial begin
		wb_cyc_out = 1'b0;
		wb_stb_out = 1'b0;
		wb_we_out = 1'b0;
		wb_adr_out = 32'h0;
		wb_sel_out = 4'h0;
		wb_dat_out = 32'h0;
	end
	// One cycle, held until ack; ok stays low when no ack comes
	task automatic access(input logic we, input logic [31:0] adr,
		input logic [31:0] dat, input logic [3:0] sel,
		output logic [31:0] q, output logic ok);
		int n;
		ok = 1'b0;
		@(posedge clock_in);
		wb_cyc_out <= 1'b1;
		wb_stb_out <= 1'b1;
		wb_we_out <= we;
		wb_adr_out <= adr;
		wb_sel_out <= sel;
		wb_dat_out <= dat;
		for (n = 0; n < 40 && !ok; n++) begin
			@(posedge clock_in);
			ok = (wb_ack_in === 1'b1);
		end
		q = wb_dat_in;
		wb_cyc_out <= 1'b0;
		wb_stb_out <= 1'b0;
		wb_adr_out <= ~adr;
		wb_dat_out <= ~dat;
	endtask : access
endmodule : wb_host_model

// *** verif/logical_device_config_regs_tb.sv ***
// Purpose: Self-checking bench for the configuration register bank
// Assumes: Index I at byte 4*I, device number at index 07
// Notes:   Each scenario drives the block and judges it before returning
`timescale 1ns/1ps
module logical_device_config_regs_tb;
	// Bus and pins
	logic        clock_in, srst_in, wb_cyc_in, wb_stb_in, wb_we_in;
	logic [31:0] wb_adr_in, wb_dat_in, wb_dat_out;
	logic [3:0]  wb_sel_in, high_addr_out, pp_fifo_threshold_out;
	logic        wb_ack_out, density_in, density_out, boot_valid_out;
	logic [1:0]  boot_drive_out, drive_a_type_out, drive_b_type_out;
	logic [7:0]  drive0_settings_out, drive1_settings_out;
	logic        disk1_access_in, disk2_access_in;
	logic        disk_primary_buffer_enable_out;
	logic        disk_secondary_buffer_enable_out;
	logic [1:0]  disk2_cs_req_in;
	logic        disk2_chip_select_a_in, disk2_chip_select_b_in;
	logic        disk2_interrupt_pin_in, chip_select_input_in;
	logic        disk2_chip_select_a_out, disk2_chip_select_a_oe_out;
	logic        disk2_chip_select_b_out, disk2_chip_select_b_oe_out;
	logic        disk2_irq_out, high_addr_valid_out;
	logic        pp_ack_in, pp_level_req_in, pp_irq_out, pp_irq_oe_out;
	logic [2:0]  pp_mode_out;
	logic        serial1_midi_out, serial1_high_speed_out;
	int          mismatches, total_checks;
	// Device and host
	logical_device_config_regs uut (
		.clock_in, .srst_in, .wb_cyc_in, .wb_stb_in, .wb_we_in,
		.wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out,
		.density_in, .density_out, .boot_drive_out, .boot_valid_out,
		.drive_a_type_out, .drive_b_type_out, .drive0_settings_out,
		.drive1_settings_out, .disk1_access_in, .disk2_access_in,
		.disk_primary_buffer_enable_out, .disk_secondary_buffer_enable_out,
		.disk2_cs_req_in, .disk2_chip_select_a_in, .disk2_chip_select_b_in,
		.disk2_interrupt_pin_in, .chip_select_input_in,
		.disk2_chip_select_a_out, .disk2_chip_select_a_oe_out,
		.disk2_chip_select_b_out, .disk2_chip_select_b_oe_out,
		.disk2_irq_out, .high_addr_out, .high_addr_valid_out, .pp_ack_in,
		.pp_level_req_in, .pp_mode_out, .pp_fifo_threshold_out, .pp_irq_out,
		.pp_irq_oe_out, .serial1_midi_out, .serial1_high_speed_out
	);
	wb_host_model u_host (
		.clock_in, .wb_ack_in(wb_ack_out), .wb_dat_in(wb_dat_out),
		.wb_cyc_out(wb_cyc_in), .wb_stb_out(wb_stb_in),
		.wb_we_out(wb_we_in), .wb_adr_out(wb_adr_in),
		.wb_sel_out(wb_sel_in), .wb_dat_out(wb_dat_in)
	);
	// 200 MHz clock
	always #2.5 clock_in = ~clock_in;
	// Counts, verdict and end of run
	task automatic close_out;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : close_out
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		total_checks++;
		if (seen !== want) begin
			mismatches++;
			$display("wrong value at %0t: %0h, want %0h", $time, seen, want);
		end
	endtask : check
	task automatic tick(input int n);
		repeat (n) @(posedge clock_in);
	endtask : tick
	// Bus access by index; a lost ack ends the run
	task automatic bus(input logic we, input logic [7:0] idx,
		input logic [7:0] d, input logic [3:0] s, output logic [31:0] q);
		logic ok;
		u_host.access(we, {22'h0, idx, 2'h0}, {24'h0, d}, s, q, ok);
		if (ok !== 1'b1) begin
			mismatches++;
			close_out();
		end
	endtask : bus
	// Writes wait two cycles so registered outputs have settled
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, idx, d, 4'h1, q);
		tick(2);
	endtask : wr
	task automatic rd_chk(input logic [7:0] idx, input logic [7:0] want);
		logic [31:0] q;
		bus(1'b0, idx, 8'h00, 4'hF, q);
		check(q, {24'h0, want});
	endtask : rd_chk
	task automatic ldn(input logic [7:0] n);
		wr(8'h07, n);
	endtask : ldn
	task automatic t_defaults;
		ldn(8'h00);
		rd_chk(8'hF0, 8'h0E);
		rd_chk(8'hF1, 8'h00);
		rd_chk(8'hF2, 8'hFF);
		rd_chk(8'hF3, 8'h00);
		rd_chk(8'hF4, 8'h00);
		rd_chk(8'hF5, 8'h00);
		check(boot_valid_out, 1'b1);
		ldn(8'h01);
		rd_chk(8'hF0, 8'h00);
		ldn(8'h02);
		rd_chk(8'hF0, 8'h00);
		ldn(8'h03);
		rd_chk(8'hF0, 8'h3C);
		check(pp_mode_out, 3'h4);
		check(pp_fifo_threshold_out, 4'h7);
		ldn(8'h04);
		rd_chk(8'hF0, 8'h00);
		$display("defaults test done");
	endtask : t_defaults
	task automatic t_masks;
		logic [31:0] q;
		ldn(8'h00);
		wr(8'hF0, 8'h01);
		rd_chk(8'hF0, 8'h01);
		wr(8'hF1, 8'hFF);
		rd_chk(8'hF1, 8'hFC);
		wr(8'hF3, 8'hFF);
		rd_chk(8'hF3, 8'h00);
		wr(8'hF4, 8'hFF);
		rd_chk(8'hF4, 8'h5B);
		wr(8'hF5, 8'hFF);
		rd_chk(8'hF5, 8'h5B);
		check(drive1_settings_out, 8'h5B);
		check(drive0_settings_out, 8'h5B);
		wr(8'hF2, 8'hA5);
		check(drive_a_type_out, 2'h1);
		check(drive_b_type_out, 2'h1);
		bus(1'b1, 8'hF2, 8'h00, 4'hE, q);
		rd_chk(8'hF2, 8'hA5);
		wr(8'hF8, 8'hFF);
		rd_chk(8'hF8, 8'h00);
		ldn(8'h02);
		wr(8'hF0, 8'hFF);
		rd_chk(8'hF0, 8'h01);
		ldn(8'h01);
		wr(8'hF0, 8'hA5);
		rd_chk(8'hF0, 8'hA5);
		ldn(8'h04);
		wr(8'hF0, 8'hFD);
		rd_chk(8'hF0, 8'h01);
		check({serial1_midi_out, serial1_high_speed_out}, 2'h2);
		wr(8'hF0, 8'h02);
		check({serial1_midi_out, serial1_high_speed_out}, 2'h1);
		$display("masks test done");
	endtask : t_masks
	task automatic t_density;
		logic [2:0] c;
		ldn(8'h00);
		for (int i = 0; i < 8; i++) begin
			c = i[2:0];
			wr(8'hF1, {4'h0, c[2:1], 2'h0});
			density_in <= c[0];
			tick(3);
			check(density_out, c[2] ? !c[1] : c[0]);
		end
		for (int b = 0; b < 4; b++) begin
			wr(8'hF1, {b[1:0], 6'h30});
			rd_chk(8'hF1, {b[1:0], 6'h30});
			check(boot_drive_out, b[1:0]);
			check(boot_valid_out, !b[1]);
		end
		$display("floppy option test done");
	endtask : t_density
	task automatic t_buffers;
		logic e;
		ldn(8'h02);
		for (int s = 0; s < 2; s++) begin
			wr(8'hF0, {7'h0, s[0]});
			for (int a = 0; a < 4; a++) begin
				disk1_access_in <= a[0];
				disk2_access_in <= a[1];
				tick(2);
				e = a[0] | (s[0] & a[1]);
				check(disk_primary_buffer_enable_out, e);
				e = !s[0] && a[1];
				check(disk_secondary_buffer_enable_out, e);
			end
		end
		$display("buffer steering test done");
	endtask : t_buffers
	task automatic t_pins;
		logic [3:0] p;
		logic act, wide;
		for (int c = 0; c < 4; c++) begin
			p = 4'h9 ^ c[3:0];
			act = c[0];
			wide = c[1];
			wr(8'h08, {6'h0, wide, act});
			disk2_cs_req_in <= p[2:1];
			disk2_interrupt_pin_in <= p[3];
			disk2_chip_select_b_in <= p[2];
			disk2_chip_select_a_in <= p[1];
			chip_select_input_in <= p[0];
			tick(2);
			check(disk2_chip_select_a_oe_out, act);
			check(disk2_chip_select_b_oe_out, act);
			check(disk2_irq_out, act & p[3]);
			check(high_addr_valid_out, !act && wide);
			check(high_addr_out[0], p[0]);
			if (act) begin
				check(disk2_chip_select_a_out, !p[1]);
				check(disk2_chip_select_b_out, !p[2]);
			end
			if (!act && wide) begin
				check(high_addr_out, p);
			end
		end
		$display("channel pins test done");
	endtask : t_pins
	task automatic t_pp_modes;
		logic [2:0] codes [7] = '{3'h4, 3'h0, 3'h1, 3'h5, 3'h2, 3'h3, 3'h7};
		ldn(8'h03);
		for (int i = 0; i < 7; i++) begin
			wr(8'hF0, {1'b0, i[3:0], codes[i]});
			rd_chk(8'hF0, {1'b0, i[3:0], codes[i]});
			check(pp_mode_out, codes[i]);
			check(pp_fifo_threshold_out, i[3:0]);
		end
		$display("port modes test done");
	endtask : t_pp_modes
	// Pulsed style first, then ack and level following per mode
	task automatic t_pp_irq;
		int n;
		logic [7:0] pm;
		ldn(8'h03);
		wr(8'hF0, 8'hBA);
		tick(3);
		pp_ack_in <= 1'b1;
		n = 0;
		repeat (12) begin
			@(posedge clock_in);
			n += (pp_irq_oe_out === 1'b1 && pp_irq_out === 1'b0);
		end
		check(n, ldcfg_pkg::PP_PULSE_CYCLES);
		check(pp_irq_oe_out, 1'b0);
		for (int m = 0; m < 4; m++) begin
			pm = m == 0 ? 8'h39 : m == 1 ? 8'hBC : m == 2 ? 8'hB8 : 8'h3A;
			wr(8'hF0, pm);
			for (int v = 0; v < 2; v++) begin
				pp_ack_in <= v[0] ^ (m == 3);
				pp_level_req_in <= v[0] ^ (m != 3);
				tick(3);
				check(pp_irq_out, v[0]);
			end
		end
		$display("port interrupt test done");
	endtask : t_pp_irq
	task automatic t_hard_reset;
		ldn(8'h03);
		wr(8'hF0, 8'h00);
		ldn(8'h00);
		wr(8'hF2, 8'h00);
		srst_in <= 1'b1;
		tick(2);
		srst_in <= 1'b0;
		tick(1);
		check(pp_mode_out, 3'h4);
		rd_chk(8'hF2, 8'hFF);
		$display("hard reset test done");
	endtask : t_hard_reset
	// Main sequence
	initial begin
		clock_in = 1'b0;
		srst_in = 1'b1;
		{density_in, disk1_access_in, disk2_access_in, disk2_cs_req_in} = '0;
		{disk2_chip_select_a_in, disk2_chip_select_b_in} = '0;
		{disk2_interrupt_pin_in, chip_select_input_in} = '0;
		{pp_ack_in, pp_level_req_in} = '0;
		mismatches = 0;
		total_checks = 0;
		repeat (12) @(posedge clock_in);
		srst_in <= 1'b0;
		t_defaults();
		t_masks();
		t_density();
		t_buffers();
		t_pins();
		t_pp_modes();
		t_pp_irq();
		t_hard_reset();
		close_out();
	end
endmodule : logical_device_config_regs_tb
